// [bench/lane_error_status_regs_monitor.sv]
`timescale 1ns/1ps
module lane_error_status_regs_monitor (
  input wire logic                       clk_sys,
  input wire logic                       sys_rst,
  input wire logic                       port_soft_rst,
  input wire logic                       port_is_odd,
  input wire logic                       merged_mode,
  input wire lane_err_pkg::ltssm_t       ltssm_state,
  input wire lane_err_pkg::lane_events_t lane_events,
  input wire logic [11:0]                address,
  input wire logic                       read,
  input wire logic                       write,
  input wire logic [31:0]                writedata,
  input wire logic [3:0]                 byteenable,
  input wire logic [31:0]                readdata,
  input wire logic                       waitrequest,
  input wire logic                       lane_error_seen
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic mapped;
  logic ack_rd;
  assign mapped = address == 12'h051c || address == 12'h0520;
  assign ack_rd = read && !waitrequest;
  property p_ack_one;
    waitrequest && (read || write) |=> !waitrequest;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("no answer one cycle after request");
  property p_ack_short;
    !waitrequest |=> waitrequest;
  endproperty
  a_ack_short: assert property (p_ack_short)
    else $error("answer stood more than one cycle");
  property p_ack_caused;
    !waitrequest |-> $past(waitrequest) && $past(read || write);
  endproperty
  a_ack_caused: assert property (p_ack_caused)
    else $error("answer without request");
  property p_reserved_zero;
    ack_rd |-> readdata[15:8] == 8'h00 && readdata[31:24] == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits not zero");
  property p_unmapped_zero;
    ack_rd && !mapped |-> readdata == 32'h0000_0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");
  property p_upper_hidden;
    ack_rd && (port_is_odd || !merged_mode)
      |-> readdata[7:4] == 4'h0 && readdata[23:20] == 4'h0;
  endproperty
  a_upper_hidden: assert property (p_upper_hidden)
    else $error("unowned upper lanes visible");
  property p_seen_rise;
    lane_events.overflow[0] && ltssm_state == lane_err_pkg::LTSSM_L0
      |-> ##[1:4] lane_error_seen;
  endproperty
  a_seen_rise: assert property (p_seen_rise)
    else $error("logged overflow not reported");
  property p_seen_hold;
    lane_error_seen && !write && !$past(write) && !port_soft_rst
      && !$past(port_soft_rst) && $stable(merged_mode)
      && $stable(port_is_odd) |=> lane_error_seen;
  endproperty
  a_seen_hold: assert property (p_seen_hold)
    else $error("stored error dropped without clear");
  c_read: cover property (ack_rd);
  c_write: cover property (write && !waitrequest);
  c_seen: cover property ($rose(lane_error_seen));
endmodule : lane_error_status_regs_monitor

bind lane_error_status_regs lane_error_status_regs_monitor
  lane_error_status_regs_monitor_inst (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .port_soft_rst(port_soft_rst),
  .port_is_odd(port_is_odd), .merged_mode(merged_mode),
  .ltssm_state(ltssm_state), .lane_events(lane_events),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .lane_error_seen(lane_error_seen));

// [bench/lane_rx_model.sv]
`timescale 1ns/1ps
// ****************************************************************
// lane receivers of the far link: one-cycle error flags per lane
// ****************************************************************
module lane_rx_model (
  input  wire logic                  clk_sys,
  input  wire logic                  fire,
  input  wire logic [1:0]            kind,
  input  wire logic [7:0]            lanes,
  output lane_err_pkg::lane_events_t lane_events
);
  // a single bad symbol flags for one cycle only, the harshest case;
  // the first edge clears the flags well inside the bench's reset
  always @(posedge clk_sys) begin
    lane_events <= '0;
    if (fire) begin
      case (kind)
        2'h0: lane_events.disparity <= lanes;
        2'h1: lane_events.decode <= lanes;
        2'h2: lane_events.underflow <= lanes;
        default: lane_events.overflow <= lanes;
      endcase
    end
  end
endmodule : lane_rx_model

// [bench/test_lane_error_status_regs.sv]
`timescale 1ns/1ps
module test_lane_error_status_regs;
  typedef struct packed {
    lane_err_pkg::ltssm_t st;
    logic                 odd;
    logic                 mrg;
    logic [1:0]           kind;
    logic [7:0]           lanes;
    logic [31:0]          exp;
  } row_t;
  localparam row_t ROWS [12] = '{
    '{lane_err_pkg::LTSSM_L0, 1'b0, 1'b1, 2'h0, 8'ha5, 32'h0000_00a5},
    '{lane_err_pkg::LTSSM_RECOVERY, 1'b0, 1'b1, 2'h0, 8'hff, 32'h0},
    '{lane_err_pkg::LTSSM_L0, 1'b0, 1'b1, 2'h1, 8'h3c, 32'h003c_0000},
    '{lane_err_pkg::LTSSM_CONFIG, 1'b0, 1'b1, 2'h1, 8'h01, 32'h0001_0000},
    '{lane_err_pkg::LTSSM_DISABLED, 1'b0, 1'b1, 2'h1, 8'h80, 32'h0080_0000},
    '{lane_err_pkg::LTSSM_HOT_RESET, 1'b0, 1'b1, 2'h1, 8'h42, 32'h0042_0000},
    '{lane_err_pkg::LTSSM_POLLING, 1'b0, 1'b1, 2'h1, 8'hff, 32'h0},
    '{lane_err_pkg::LTSSM_L0, 1'b0, 1'b1, 2'h2, 8'h5a, 32'h0000_005a},
    '{lane_err_pkg::LTSSM_L1, 1'b0, 1'b1, 2'h2, 8'hff, 32'h0},
    '{lane_err_pkg::LTSSM_L0, 1'b0, 1'b1, 2'h3, 8'hc3, 32'h00c3_0000},
    '{lane_err_pkg::LTSSM_L0, 1'b0, 1'b0, 2'h3, 8'hff, 32'h000f_0000},
    '{lane_err_pkg::LTSSM_L0, 1'b1, 1'b1, 2'h0, 8'hff, 32'h0000_000f}};
  logic                       clk_sys = 1'b0;
  logic                       sys_rst = 1'b1;
  logic                       port_soft_rst = 1'b0;
  logic                       port_is_odd = 1'b0;
  logic                       merged_mode = 1'b1;
  lane_err_pkg::ltssm_t       ltssm_state = lane_err_pkg::LTSSM_L0;
  lane_err_pkg::lane_events_t lane_events;
  logic [11:0]                address = 12'h000;
  logic                       read = 1'b0;
  logic                       write = 1'b0;
  logic [31:0]                writedata = 32'h0;
  logic [3:0]                 byteenable = 4'h0;
  logic [31:0]                readdata;
  logic                       waitrequest;
  logic                       lane_error_seen;
  logic                       fire = 1'b0;
  logic [1:0]                 kind = 2'h0;
  logic [7:0]                 lanes = 8'h00;
  logic [31:0]                q;
  logic [11:0]                row_addr;
  string                      row_name;
  row_t                       r;
  int                         num_errors = 0;
  int                         n_checks = 0;
  int                         cycles = 0;

  always #2 clk_sys = ~clk_sys;

  lane_error_status_regs lane_error_status_regs_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .port_soft_rst(port_soft_rst),
    .port_is_odd(port_is_odd), .merged_mode(merged_mode),
    .ltssm_state(ltssm_state), .lane_events(lane_events),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .lane_error_seen(lane_error_seen));
  lane_rx_model lane_rx_model_inst (
    .clk_sys(clk_sys), .fire(fire), .kind(kind), .lanes(lanes),
    .lane_events(lane_events));

  task automatic results();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // the request stands until waitrequest is seen low at a rising edge;
  // values read right at an edge are the ones the slave held before it
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_sys);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    byteenable <= be;
    @(posedge clk_sys);
    while (waitrequest !== 1'b0) @(posedge clk_sys);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input string nm);
    bus(1'b0, a, 32'h0, 4'h0);
    chk(nm, e, q);
  endtask : rd

  task automatic clr();
    bus(1'b1, 12'h051c, 32'hffff_ffff, 4'hf);
    bus(1'b1, 12'h0520, 32'hffff_ffff, 4'hf);
  endtask : clr

  task automatic inject(input logic [1:0] k, input logic [7:0] l);
    @(posedge clk_sys);
    fire <= 1'b1;
    kind <= k;
    lanes <= l;
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : inject

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      results();
    end
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(12'h051c, 32'h0, "coding after reset");
    rd(12'h0520, 32'h0, "elastic after reset");
    foreach (ROWS[i]) begin
      r = ROWS[i];
      @(posedge clk_sys);
      ltssm_state <= r.st;
      port_is_odd <= r.odd;
      merged_mode <= r.mrg;
      inject(r.kind, r.lanes);
      row_addr = r.kind[1] ? 12'h0520 : 12'h051c;
      row_name = $sformatf("row %0d", i);
      rd(row_addr, r.exp, row_name);
      clr();
    end
    @(posedge clk_sys);
    ltssm_state <= lane_err_pkg::LTSSM_L0;
    port_is_odd <= 1'b0;
    merged_mode <= 1'b1;
    inject(2'h0, 8'hff);
    inject(2'h1, 8'hff);
    bus(1'b1, 12'h051c, 32'h0000_0003, 4'hf);
    bus(1'b1, 12'h051c, 32'h0000_0000, 4'hf);
    rd(12'h051c, 32'h00ff_00fc, "partial clear");
    bus(1'b1, 12'h051c, 32'hffff_ffff, 4'h1);
    bus(1'b1, 12'h051c, 32'hff00_ff00, 4'hf);
    bus(1'b1, 12'h051c, 32'h00f0_0000, 4'h3);
    bus(1'b1, 12'h0524, 32'hffff_ffff, 4'hf);
    rd(12'h0524, 32'h0, "unmapped");
    rd(12'h051c, 32'h00ff_0000, "byte clear");
    chk("seen set", 32'h1, {31'h0, lane_error_seen});
    clr();
    repeat (2) @(posedge clk_sys);
    chk("seen clear", 32'h0, {31'h0, lane_error_seen});
    inject(2'h0, 8'h01);
    inject(2'h2, 8'h02);
    inject(2'h3, 8'h04);
    @(posedge clk_sys);
    port_soft_rst <= 1'b1;
    @(posedge clk_sys);
    port_soft_rst <= 1'b0;
    rd(12'h051c, 32'h0, "soft reset coding");
    rd(12'h0520, 32'h0004_0002, "soft reset elastic");
    inject(2'h3, 8'h80);
    rd(12'h0520, 32'h0084_0002, "merged upper");
    @(posedge clk_sys);
    merged_mode <= 1'b0;
    rd(12'h0520, 32'h0004_0002, "unmerged upper");
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(12'h0520, 32'h0, "full reset elastic");
    results();
  end
endmodule : test_lane_error_status_regs

// [pkg/lane_err_pkg.sv]
// ****************************************************************
// lane error status constants and carriers
// ****************************************************************
package lane_err_pkg;

  localparam int unsigned LANE_COUNT = 8;
  localparam int unsigned HALF_LANES = 4;
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned BE_W       = 4;

  // ****************************************************************
  // register map, byte addresses
  // ****************************************************************
  localparam logic [ADDR_W-1:0] CODING_STS_OFS  = 12'h051c;
  localparam logic [ADDR_W-1:0] ELASTIC_STS_OFS = 12'h0520;

  // ****************************************************************
  // field layout: low field in byte 0, high field in byte 2
  // ****************************************************************
  localparam int unsigned LO_FIELD_LSB = 0;
  localparam int unsigned HI_FIELD_LSB = 16;
  localparam int unsigned LO_FIELD_BE  = 0;
  localparam int unsigned HI_FIELD_BE  = 2;

  localparam logic [LANE_COUNT-1:0] FIELD_RESET = 8'h00;
  localparam logic [LANE_COUNT-1:0] ALL_LANES   = 8'hff;
  localparam logic [LANE_COUNT-1:0] LOW_LANES   = 8'h0f;
  localparam logic [DATA_W-1:0]     READ_ZERO   = 32'h0000_0000;

  // ****************************************************************
  // link training state code as driven by the training machine
  // ****************************************************************
  typedef enum logic [3:0] {
    LTSSM_DETECT    = 4'h0,
    LTSSM_POLLING   = 4'h1,
    LTSSM_CONFIG    = 4'h2,
    LTSSM_L0        = 4'h3,
    LTSSM_RECOVERY  = 4'h4,
    LTSSM_L0S       = 4'h5,
    LTSSM_L1        = 4'h6,
    LTSSM_L2        = 4'h7,
    LTSSM_DISABLED  = 4'h8,
    LTSSM_LOOPBACK  = 4'h9,
    LTSSM_HOT_RESET = 4'ha
  } ltssm_t;

  // per-lane one-cycle event pulses from the lane receivers
  typedef struct packed {
    logic [LANE_COUNT-1:0] disparity;
    logic [LANE_COUNT-1:0] decode;
    logic [LANE_COUNT-1:0] underflow;
    logic [LANE_COUNT-1:0] overflow;
  } lane_events_t;

  // bus request as seen by the register logic
  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [BE_W-1:0]   byteenable;
  } bus_req_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;

endpackage : lane_err_pkg

// [verilog/avmm_reg_port.sv]
`timescale 1ns/1ps
// ****************************************************************
// avalon-mm slave handshake: one wait cycle, then acknowledge
// ****************************************************************
module avmm_reg_port (
  input  wire logic                           clk_sys,
  input  wire logic                           sys_rst,
  input  wire lane_err_pkg::bus_req_t         req,
  input  wire logic [lane_err_pkg::DATA_W-1:0] read_value,
  output logic                                waitrequest,
  output logic [lane_err_pkg::DATA_W-1:0]     readdata,
  output logic                                write_strobe
);

  typedef struct packed {
    lane_err_pkg::bus_state_t        bus;
    logic [lane_err_pkg::DATA_W-1:0] rdata;
  } port_state_t;

  port_state_t state_reg;
  port_state_t state_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg.bus)
      lane_err_pkg::BUS_IDLE: begin
        if (req.read || req.write) begin
          state_next.bus   = lane_err_pkg::BUS_ACK;
          // read data is latched so it stands through the ack cycle
          state_next.rdata = req.read ? read_value :
                             lane_err_pkg::READ_ZERO;
        end
      end
      lane_err_pkg::BUS_ACK: begin
        state_next.bus = lane_err_pkg::BUS_IDLE;
      end
      default: begin
        state_next.bus = lane_err_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg.bus   <= lane_err_pkg::BUS_IDLE;
      state_reg.rdata <= lane_err_pkg::READ_ZERO;
    end else begin
      state_reg <= state_next;
    end
  end

  assign waitrequest  = (state_reg.bus != lane_err_pkg::BUS_ACK);
  assign readdata     = state_reg.rdata;
  assign write_strobe = (state_reg.bus == lane_err_pkg::BUS_ACK) &&
                        req.write;

endmodule : avmm_reg_port

// [verilog/lane_error_status_regs.sv]
`timescale 1ns/1ps
// Behaviour
// - each bit of an eight-bit field belongs to the lane of equal number.
// - a running disparity error on a lane sets its disparity bit.
// - disparity errors are logged only while training is in L0.
// - an 8b/10b decode error on a lane sets its decode bit.
// - decode errors log only in L0, Configuration, Disabled or Hot-Reset.
// - a receiver that inserts zero bytes sets its underflow bit in L0 only.
// - a receiver that drops bytes sets its overflow bit in L0 only.
// - writing one clears a status bit, zero leaves it, set bits hold.
// - underflow and overflow survive the port reset, the others do not.
// - on an even port the upper four lanes count only when merged.
// - on an odd port the upper four lanes never count.
module lane_error_status_regs (
  input  wire logic                                clk_sys,
  input  wire logic                                sys_rst,
  input  wire logic                                port_soft_rst,
  input  wire logic                                port_is_odd,
  input  wire logic                                merged_mode,
  input  wire lane_err_pkg::ltssm_t                ltssm_state,
  input  wire lane_err_pkg::lane_events_t          lane_events,
  input  wire logic [lane_err_pkg::ADDR_W-1:0]     address,
  input  wire logic                                read,
  input  wire logic                                write,
  input  wire logic [lane_err_pkg::DATA_W-1:0]     writedata,
  input  wire logic [lane_err_pkg::BE_W-1:0]       byteenable,
  output logic [lane_err_pkg::DATA_W-1:0]          readdata,
  output logic                                     waitrequest,
  output logic                                     lane_error_seen
);

  // ****************************************************************
  // state of this level: the qualified events, one stage deep
  // ****************************************************************
  typedef struct packed {
    lane_err_pkg::lane_events_t    qual;
    logic                          any_flag;
  } top_state_t;

  top_state_t                          state_reg;
  top_state_t                          state_next;

  lane_err_pkg::bus_req_t              req;
  logic                                write_strobe;
  logic [lane_err_pkg::DATA_W-1:0]     read_value;

  logic                                in_l0;
  logic                                decode_window;
  logic [lane_err_pkg::LANE_COUNT-1:0] lane_mask;

  logic [lane_err_pkg::LANE_COUNT-1:0] disparity_error_bits;
  logic [lane_err_pkg::LANE_COUNT-1:0] decode_error_bits;
  logic [lane_err_pkg::LANE_COUNT-1:0] rx_underflow_bits;
  logic [lane_err_pkg::LANE_COUNT-1:0] rx_overflow_bits;

  logic [lane_err_pkg::LANE_COUNT-1:0] clr_disparity;
  logic [lane_err_pkg::LANE_COUNT-1:0] clr_decode;
  logic [lane_err_pkg::LANE_COUNT-1:0] clr_underflow;
  logic [lane_err_pkg::LANE_COUNT-1:0] clr_overflow;

  logic                                hit_coding;
  logic                                hit_elastic;
  logic                                lo_lane_wr;
  logic                                hi_lane_wr;
  logic [lane_err_pkg::LANE_COUNT-1:0] wr_lo_field;
  logic [lane_err_pkg::LANE_COUNT-1:0] wr_hi_field;

  // ****************************************************************
  // training state gating
  // ****************************************************************
  always_comb begin
    in_l0 = (ltssm_state == lane_err_pkg::LTSSM_L0);
    case (ltssm_state)
      lane_err_pkg::LTSSM_L0,
      lane_err_pkg::LTSSM_CONFIG,
      lane_err_pkg::LTSSM_DISABLED,
      lane_err_pkg::LTSSM_HOT_RESET: begin
        decode_window = 1'b1;
      end
      default: begin
        decode_window = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // lane ownership
  // ****************************************************************
  // the upper lanes have no defined status unless this port owns them;
  // we keep them at zero rather than let stray events leak in
  always_comb begin
    if (port_is_odd) begin
      lane_mask = lane_err_pkg::LOW_LANES;
    end else if (merged_mode) begin
      lane_mask = lane_err_pkg::ALL_LANES;
    end else begin
      lane_mask = lane_err_pkg::LOW_LANES;
    end
  end

  // ****************************************************************
  // event qualification
  // ****************************************************************
  // one register stage eases timing from the lane receivers; an event
  // therefore shows in the status one cycle after it is sampled
  always_comb begin
    state_next = state_reg;
    state_next.qual.disparity =
      lane_events.disparity & lane_mask & {8{in_l0}};
    state_next.qual.decode =
      lane_events.decode & lane_mask & {8{decode_window}};
    state_next.qual.underflow =
      lane_events.underflow & lane_mask & {8{in_l0}};
    state_next.qual.overflow =
      lane_events.overflow & lane_mask & {8{in_l0}};
    state_next.any_flag = |{disparity_error_bits, decode_error_bits,
                            rx_underflow_bits, rx_overflow_bits};
    // a port reset drops events still in flight for the plain fields
    if (port_soft_rst) begin
      state_next.qual.disparity = lane_err_pkg::FIELD_RESET;
      state_next.qual.decode    = lane_err_pkg::FIELD_RESET;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg.qual.disparity <= lane_err_pkg::FIELD_RESET;
      state_reg.qual.decode    <= lane_err_pkg::FIELD_RESET;
      state_reg.qual.underflow <= lane_err_pkg::FIELD_RESET;
      state_reg.qual.overflow  <= lane_err_pkg::FIELD_RESET;
      state_reg.any_flag       <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign lane_error_seen = state_reg.any_flag;

  // ****************************************************************
  // bus port
  // ****************************************************************
  always_comb begin
    req.read       = read;
    req.write      = write;
    req.address    = address;
    req.writedata  = writedata;
    req.byteenable = byteenable;
  end

  avmm_reg_port u_port (
    .clk_sys      (clk_sys),
    .sys_rst      (sys_rst),
    .req          (req),
    .read_value   (read_value),
    .waitrequest  (waitrequest),
    .readdata     (readdata),
    .write_strobe (write_strobe)
  );

  // ****************************************************************
  // address decode and write-one-to-clear masks
  // ****************************************************************
  // only bytes 0 and 2 carry fields; writes to reserved bytes are lost
  always_comb begin
    hit_coding  = (address == lane_err_pkg::CODING_STS_OFS);
    hit_elastic = (address == lane_err_pkg::ELASTIC_STS_OFS);
    lo_lane_wr  = write_strobe &
                  byteenable[lane_err_pkg::LO_FIELD_BE];
    hi_lane_wr  = write_strobe &
                  byteenable[lane_err_pkg::HI_FIELD_BE];
    wr_lo_field = writedata[lane_err_pkg::LO_FIELD_LSB +:
                            lane_err_pkg::LANE_COUNT];
    wr_hi_field = writedata[lane_err_pkg::HI_FIELD_LSB +:
                            lane_err_pkg::LANE_COUNT];
    clr_disparity = wr_lo_field & {8{hit_coding  & lo_lane_wr}};
    clr_decode    = wr_hi_field & {8{hit_coding  & hi_lane_wr}};
    clr_underflow = wr_lo_field & {8{hit_elastic & lo_lane_wr}};
    clr_overflow  = wr_hi_field & {8{hit_elastic & hi_lane_wr}};
  end

  // ****************************************************************
  // flag fields
  // ****************************************************************
  lane_flag_field #(
    .WIDTH  (lane_err_pkg::LANE_COUNT),
    .STICKY (1'b0)
  ) u_disparity (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .soft_rst   (port_soft_rst),
    .set_bits   (state_reg.qual.disparity),
    .clear_bits (clr_disparity),
    .flags      (disparity_error_bits)
  );

  lane_flag_field #(
    .WIDTH  (lane_err_pkg::LANE_COUNT),
    .STICKY (1'b0)
  ) u_decode (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .soft_rst   (port_soft_rst),
    .set_bits   (state_reg.qual.decode),
    .clear_bits (clr_decode),
    .flags      (decode_error_bits)
  );

  lane_flag_field #(
    .WIDTH  (lane_err_pkg::LANE_COUNT),
    .STICKY (1'b1)
  ) u_underflow (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .soft_rst   (port_soft_rst),
    .set_bits   (state_reg.qual.underflow),
    .clear_bits (clr_underflow),
    .flags      (rx_underflow_bits)
  );

  lane_flag_field #(
    .WIDTH  (lane_err_pkg::LANE_COUNT),
    .STICKY (1'b1)
  ) u_overflow (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .soft_rst   (port_soft_rst),
    .set_bits   (state_reg.qual.overflow),
    .clear_bits (clr_overflow),
    .flags      (rx_overflow_bits)
  );

  // ****************************************************************
  // read back
  // ****************************************************************
  // unowned lanes are masked on read too, so a change of merge mode
  // cannot expose bits captured under the other lane ownership
  always_comb begin
    read_value = lane_err_pkg::READ_ZERO;
    if (hit_coding) begin
      read_value[lane_err_pkg::LO_FIELD_LSB +: lane_err_pkg::LANE_COUNT] =
        disparity_error_bits & lane_mask;
      read_value[lane_err_pkg::HI_FIELD_LSB +: lane_err_pkg::LANE_COUNT] =
        decode_error_bits & lane_mask;
    end else if (hit_elastic) begin
      read_value[lane_err_pkg::LO_FIELD_LSB +: lane_err_pkg::LANE_COUNT] =
        rx_underflow_bits & lane_mask;
      read_value[lane_err_pkg::HI_FIELD_LSB +: lane_err_pkg::LANE_COUNT] =
        rx_overflow_bits & lane_mask;
    end
  end

endmodule : lane_error_status_regs

// [verilog/lane_flag_field.sv]
`timescale 1ns/1ps
// ****************************************************************
// write-one-to-clear flag field, optionally sticky
// ****************************************************************
module lane_flag_field #(
  parameter int unsigned WIDTH  = 8,
  parameter bit          STICKY = 1'b0
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             soft_rst,
  input  wire logic [WIDTH-1:0] set_bits,
  input  wire logic [WIDTH-1:0] clear_bits,
  output logic      [WIDTH-1:0] flags
);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } field_state_t;

  field_state_t     state_reg;
  field_state_t     state_next;
  logic [WIDTH-1:0] bit_next;
  logic             wipe;

  // sticky fields survive the port's non-fundamental reset
  assign wipe = soft_rst & ~STICKY;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // a set in the clearing cycle wins over the clear
      assign bit_next[i] = wipe ? 1'b0 :
        (set_bits[i] | (state_reg.flags[i] & ~clear_bits[i]));
    end
  endgenerate

  always_comb begin
    state_next       = state_reg;
    state_next.flags = bit_next;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg.flags <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign flags = state_reg.flags;

endmodule : lane_flag_field
